// ---- logic/asc_host.sv ----
// Host controller that reads and writes an asynchronous 64K x 16 static memory
// Notes on behaviour
// [R1] The memory holds 65536 words of 16 bits, upper byte on data lines 15..8, lower on 7..0.
// [R2] The memory needs no clock or refresh; only pin levels and edges matter to it.
// [R3] With select high the memory floats both lanes and ignores every other control.
// [R4] A read drives each lane whose lane enable is low when select and drive enable are low, strobe high.
// [R5] A write takes only lanes whose enable is low, whatever the drive enable does.
// [R6] Both lanes float when drive enable and strobe are high, or when both lane enables are high.
// [R7] A write lasts only while select, strobe and one lane enable are all low together.
// [R8] With drive enable low during a strobe write the pulse covers turn-off delay plus data set-up.
// [R9] The host never drives data lines while the memory drives them.
// [R10] Select or lane enables falling with or after the strobe keep the memory outputs off.
// [R11] The address is valid no later than the last falling select or lane enable of a read.
// [R12] The strobe stays high outside writes and the address moves only outside a write overlap.
`timescale 1ns/1ns
module asc_host #(
    parameter int RD_CYC = asc_pkg::ASC_RD_CYC,
    parameter int WP_CYC = asc_pkg::ASC_WP_CYC,
    parameter int TURN_CYC = asc_pkg::ASC_TURN_CYC
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire asc_pkg::asc_req_t req_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    output logic [asc_pkg::ASC_DATA_W-1:0] rdata_o,
    output logic rdata_valid_o,
    output asc_pkg::asc_pins_t pins_o,
    input wire logic [asc_pkg::ASC_DATA_W-1:0] data_lines_i,
    output logic [asc_pkg::ASC_DATA_W-1:0] data_lines_o,
    output logic [asc_pkg::ASC_DATA_W-1:0] data_lines_oe_o
);
    import asc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_READ = 3'b001,
        ST_WSETUP = 3'b010,
        ST_WPULSE = 3'b011,
        ST_WHOLD = 3'b100,
        ST_TURN = 3'b101
    } asc_state_t;

    typedef struct packed {
        asc_state_t state;
        logic [ASC_CNT_W-1:0] cnt;
        asc_pins_t pins;
        logic [ASC_DATA_W-1:0] wdata;
        logic drive;
        logic [ASC_DATA_W-1:0] rdata;
        logic rvalid;
    } asc_host_st_t;

    asc_host_st_t st_r;
    asc_host_st_t st_nxt;
    logic [ASC_DATA_W-1:0] data_sync;

    // Pins come back asynchronously, so read data passes two flops first
    asc_sync #(
        .WIDTH(ASC_DATA_W)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .async_i(data_lines_i),
        .sync_o(data_sync)
    );

    localparam logic [ASC_CNT_W-1:0] RD_LAST = ASC_CNT_W'(RD_CYC + 1);
    localparam logic [ASC_CNT_W-1:0] WP_LAST = ASC_CNT_W'(WP_CYC - 1);
    localparam logic [ASC_CNT_W-1:0] TURN_LAST = ASC_CNT_W'(TURN_CYC - 1);

    always_comb begin
        st_nxt = st_r;
        st_nxt.rvalid = 1'b0;
        unique case (st_r.state)
            ST_IDLE: begin
                st_nxt.pins = ASC_PINS_IDLE; // [R12]
                st_nxt.pins.word_address = st_r.pins.word_address;
                st_nxt.drive = 1'b0;
                st_nxt.cnt = ASC_CNT_ZERO;
                if (req_valid_i && (req_i.upper_lane || req_i.lower_lane)) begin
                    // Address and controls move in the same edge; select and lane enables fall together
                    st_nxt.pins.word_address = req_i.word_address; // [R11]
                    st_nxt.pins.select_n = 1'b0;
                    if (req_i.write) begin
                        // Outputs held off first so no read can start before the strobe
                        st_nxt.pins.drive_enable_n = 1'b1; // [R10]
                        st_nxt.wdata = req_i.wdata;
                        st_nxt.state = ST_WSETUP;
                    end else begin
                        st_nxt.pins.drive_enable_n = 1'b0; // [R4]
                        st_nxt.pins.upper_lane_enable_n = ~req_i.upper_lane;
                        st_nxt.pins.lower_lane_enable_n = ~req_i.lower_lane;
                        st_nxt.state = ST_READ;
                    end
                    st_nxt.pins.upper_lane_enable_n = ~req_i.upper_lane; // [R5]
                    st_nxt.pins.lower_lane_enable_n = ~req_i.lower_lane;
                end
            end
            ST_READ: begin
                // Wait access time plus the synchroniser depth
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt == RD_LAST) begin
                    st_nxt.rdata = data_sync;
                    st_nxt.rvalid = 1'b1;
                    st_nxt.pins.select_n = 1'b1; // [R3]
                    st_nxt.pins.drive_enable_n = 1'b1; // [R6]
                    st_nxt.cnt = ASC_CNT_ZERO;
                    st_nxt.state = ST_TURN;
                end
            end
            ST_WSETUP: begin
                // Memory is not driving: drive enable high since the request
                st_nxt.drive = 1'b1; // [R9]
                st_nxt.pins.write_strobe_n = 1'b0; // [R7]
                st_nxt.cnt = ASC_CNT_ZERO;
                st_nxt.state = ST_WPULSE;
            end
            ST_WPULSE: begin
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt == WP_LAST) begin
                    st_nxt.pins.write_strobe_n = 1'b1; // [R8]
                    st_nxt.state = ST_WHOLD;
                end
            end
            ST_WHOLD: begin
                // Data and address stay one cycle past the strobe rise
                st_nxt.drive = 1'b0;
                st_nxt.pins.select_n = 1'b1;
                st_nxt.pins.upper_lane_enable_n = 1'b1;
                st_nxt.pins.lower_lane_enable_n = 1'b1;
                st_nxt.cnt = ASC_CNT_ZERO;
                st_nxt.state = ST_IDLE;
            end
            ST_TURN: begin
                // Lets the memory drivers release before the next write drives the lines
                st_nxt.cnt = st_r.cnt + 1'b1;
                if (st_r.cnt == TURN_LAST) begin
                    st_nxt.pins.upper_lane_enable_n = 1'b1;
                    st_nxt.pins.lower_lane_enable_n = 1'b1;
                    st_nxt.cnt = ASC_CNT_ZERO;
                    st_nxt.state = ST_IDLE;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '{state: ST_IDLE, cnt: ASC_CNT_ZERO, pins: ASC_PINS_IDLE, wdata: '0, drive: 1'b0,
                      rdata: '0, rvalid: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign req_ready_o = (st_r.state == ST_IDLE);
    assign pins_o = st_r.pins;
    assign rdata_o = st_r.rdata;
    assign rdata_valid_o = st_r.rvalid;
    assign data_lines_o = st_r.wdata;
    // Lane drive follows the lane enables so an unwritten byte lane stays free
    assign data_lines_oe_o = {{8{st_r.drive & ~st_r.pins.upper_lane_enable_n}},
                              {8{st_r.drive & ~st_r.pins.lower_lane_enable_n}}};

    a_no_contention: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R9]
        (st_r.drive) |-> (st_r.pins.drive_enable_n && !st_r.pins.select_n))
        else $error("host drives data while memory outputs may be on");

    a_strobe_idle: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R12]
        (st_r.state == ST_IDLE || st_r.state == ST_READ || st_r.state == ST_TURN) |-> st_r.pins.write_strobe_n)
        else $error("write strobe low outside a write");

    sequence s_strobe_fall;
        $fell(st_r.pins.write_strobe_n);
    endsequence

    a_write_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R8]
        s_strobe_fall |-> (!st_r.pins.write_strobe_n && st_r.drive) [*2] ##1 st_r.pins.write_strobe_n)
        else $error("write pulse length wrong");

    a_write_overlap: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R7]
        !st_r.pins.write_strobe_n |-> (!st_r.pins.select_n &&
            !(st_r.pins.upper_lane_enable_n && st_r.pins.lower_lane_enable_n)))
        else $error("strobe low without select and lane");

    a_addr_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R12]
        (!st_r.pins.select_n && $past(!st_r.pins.select_n)) |-> $stable(st_r.pins.word_address))
        else $error("address moved during an access");

    a_write_oe_off: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R10]
        (st_r.state == ST_WSETUP) |-> (st_r.pins.drive_enable_n && st_r.pins.write_strobe_n))
        else $error("outputs enabled ahead of write strobe");

    a_read_done: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R4]
        $rose(st_r.state == ST_READ) |-> ##[1:8] st_r.rvalid)
        else $error("read did not complete");

    a_read_release: assert property (@(posedge ref_clk_i) disable iff (reset_i) // [R6]
        st_r.rvalid |-> (st_r.pins.select_n && st_r.pins.drive_enable_n && !st_r.drive))
        else $error("read end left memory selected");
endmodule

// ---- logic/asc_pkg.sv ----
// Package with constants and carrier types of the static memory host controller
package asc_pkg;
    localparam int ASC_ADDR_W = 16;
    localparam int ASC_DATA_W = 16;
    localparam int ASC_CLK_PERIOD_NS = 10;
    // Device timing figures, nanoseconds
    localparam int ASC_T_ACCESS_NS = 20;
    localparam int ASC_T_WP_NS = 12;
    localparam int ASC_T_WHZ_NS = 8;
    localparam int ASC_T_DW_NS = 9;
    localparam int ASC_T_SETUP_NS = 0;
    localparam int ASC_T_TURN_NS = 8;
    // Least times round up to whole cycles, never below one
    localparam int ASC_RD_CYC = (ASC_T_ACCESS_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS + 1;
    localparam int ASC_WP_PLAIN = (ASC_T_WP_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
    localparam int ASC_WP_OE_LOW = (ASC_T_WHZ_NS + ASC_T_DW_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
    localparam int ASC_WP_CYC = (ASC_WP_OE_LOW > ASC_WP_PLAIN) ? ASC_WP_OE_LOW : ASC_WP_PLAIN;
    localparam int ASC_TURN_CYC = (ASC_T_TURN_NS + ASC_CLK_PERIOD_NS - 1) / ASC_CLK_PERIOD_NS;
    localparam int ASC_CNT_W = 4;
    localparam logic [ASC_CNT_W-1:0] ASC_CNT_ZERO = 4'h0;

    typedef struct packed {
        logic [ASC_ADDR_W-1:0] word_address;
        logic [ASC_DATA_W-1:0] wdata;
        logic upper_lane;
        logic lower_lane;
        logic write;
    } asc_req_t;

    typedef struct packed {
        logic select_n;
        logic write_strobe_n;
        logic drive_enable_n;
        logic upper_lane_enable_n;
        logic lower_lane_enable_n;
        logic [ASC_ADDR_W-1:0] word_address;
    } asc_pins_t;

    localparam asc_pins_t ASC_PINS_IDLE = '{select_n: 1'b1, write_strobe_n: 1'b1, drive_enable_n: 1'b1,
        upper_lane_enable_n: 1'b1, lower_lane_enable_n: 1'b1, word_address: 16'h0000};
endpackage

// ---- logic/asc_sync.sv ----
// Two-stage synchroniser for the data lines read back from the memory
`timescale 1ns/1ns
module asc_sync #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } asc_sync_st_t;

    asc_sync_st_t st_r;
    asc_sync_st_t st_nxt;

    always_comb begin
        st_nxt.meta = async_i;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_o = st_r.stable;
endmodule

// ---- sim/asc_mem_model.sv ----
// Behavioural model of the asynchronous 64K x 16 static memory
`timescale 1ns/1ns
module asc_mem_model (
    input wire asc_pkg::asc_pins_t pins_i,
    input wire logic [asc_pkg::ASC_DATA_W-1:0] bus_i,
    output logic [asc_pkg::ASC_DATA_W-1:0] data_o,
    output logic [asc_pkg::ASC_DATA_W-1:0] data_oe_o
);
    import asc_pkg::*;
    // No clock: contents and lanes follow pin levels only
    logic [ASC_DATA_W-1:0] mem [0:65535];
    logic [ASC_DATA_W-1:0] last = 16'h5a3c;
    logic rd;
    logic wr;
    // Strobe low keeps outputs off however select and lanes fall
    assign rd = !pins_i.select_n && !pins_i.drive_enable_n && pins_i.write_strobe_n;
    assign wr = !pins_i.select_n && !pins_i.write_strobe_n;
    assign data_oe_o = {{8{rd && !pins_i.upper_lane_enable_n}}, {8{rd && !pins_i.lower_lane_enable_n}}};
    // Floating lanes show the inverse of the last read, so stale data never passes
    assign data_o = (data_oe_o & mem[pins_i.word_address]) | (~data_oe_o & ~last);
    always @(rd or wr or pins_i or bus_i) begin
        if (rd) begin
            last = mem[pins_i.word_address];
        end
        if (wr && !pins_i.upper_lane_enable_n) begin
            mem[pins_i.word_address][15:8] = bus_i[15:8];
        end
        if (wr && !pins_i.lower_lane_enable_n) begin
            mem[pins_i.word_address][7:0] = bus_i[7:0];
        end
    end
endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the static memory host controller
`timescale 1ns/1ns
module testbench;
    import asc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    asc_req_t req_i = '0;
    logic req_valid_i = 1'b0;
    logic req_ready_o;
    logic rdata_valid_o;
    logic [15:0] rdata_o;
    logic [15:0] host_o;
    logic [15:0] host_oe;
    logic [15:0] mdl_o;
    logic [15:0] mdl_oe;
    logic [15:0] bus;
    asc_pins_t pins_o;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int wp_len = 0;
    logic [15:0] shadow [bit [15:0]];
    logic [15:0] addrs [8];

    always #5 ref_clk_i = ~ref_clk_i;
    // Host wins where it drives; overlap is flagged by the monitor
    assign bus = (host_oe & host_o) | (~host_oe & mdl_o);

    asc_host dut_u (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .pins_o(pins_o),
        .data_lines_i(bus), .data_lines_o(host_o), .data_lines_oe_o(host_oe));
    asc_mem_model mem_u (.pins_i(pins_o), .bus_i(bus), .data_o(mdl_o), .data_oe_o(mdl_oe));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] lanes(input logic up, input logic lo);
        return {{8{up}}, {8{lo}}};
    endfunction

    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic up, input logic lo);
        int n;
        n = 0;
        while (req_ready_o !== 1'b1 && n < 20) begin
            @(posedge ref_clk_i);
            #1;
            n++;
        end
        req_i = '{word_address: a, wdata: d, upper_lane: up, lower_lane: lo, write: wr};
        req_valid_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        req_valid_i = 1'b0;
        n = 0;
        if (wr) begin
            shadow[a] = (shadow[a] & ~lanes(up, lo)) | (d & lanes(up, lo));
        end else begin
            while (rdata_valid_o !== 1'b1 && n < 20) begin
                @(posedge ref_clk_i);
                #1;
                n++;
            end
            chk("read latency", 16'(ASC_RD_CYC + 2), 16'(n));
            chk("read data", shadow[a] & lanes(up, lo), rdata_o & lanes(up, lo));
        end
    endtask

    // Wire monitor on the falling edge, where registered pins have settled; a stuck run hits the ceiling
    always @(negedge ref_clk_i) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            final_report();
        end else if (!reset_i) begin
            chk("contention", 16'h0000, host_oe & mdl_oe);
            chk("strobe overlap", 16'h0001, 16'(pins_o.write_strobe_n | (!pins_o.select_n &&
                !(pins_o.upper_lane_enable_n && pins_o.lower_lane_enable_n))));
            if (pins_o.write_strobe_n === 1'b0) begin
                wp_len++;
            end else if (wp_len > 0) begin
                chk("strobe width", 16'h0001, 16'(wp_len >= ASC_WP_CYC));
                wp_len = 0;
            end
        end
    end

    initial begin
        logic up;
        logic lo;
        void'($urandom(69327));
        repeat (4) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        chk("idle select", 16'h0001, 16'(pins_o.select_n));
        addrs[0] = 16'h0000;
        addrs[1] = 16'hffff;
        for (int i = 2; i < 8; i++) begin
            addrs[i] = 16'($urandom());
        end
        foreach (addrs[i]) begin
            access(1'b1, addrs[i], 16'($urandom()), 1'b1, 1'b1);
        end
        // A request without lanes must leave the pins idle; let the last write finish first
        repeat (5) @(posedge ref_clk_i);
        #1;
        req_i = '{word_address: 16'h1234, wdata: 16'hbeef, upper_lane: 1'b0, lower_lane: 1'b0, write: 1'b1};
        req_valid_i = 1'b1;
        repeat (3) @(posedge ref_clk_i);
        #1;
        req_valid_i = 1'b0;
        chk("ignored request", 16'h0001, 16'(pins_o.select_n & req_ready_o));
        for (int i = 0; i < 80; i++) begin
            up = 1'($urandom_range(1));
            lo = 1'($urandom_range(1)) | !up;
            access(1'($urandom_range(1)), addrs[$urandom_range(7)], 16'($urandom()), up, lo);
        end
        foreach (addrs[i]) begin
            access(1'b0, addrs[i], 16'h0000, 1'b1, 1'b1);
        end
        final_report();
    end
endmodule
